//--- rtl/adcp_ctrl.sv
// Converter control: registers, bit-period timing, acquisition and conversion sequence.
// Assumes a successive-approximation comparator input from the analog macro,
// pins already synchronised by the port logic, and a free-running RC clock tick.
//
// Notes on behaviour
// - Zero acquisition code delays conversion start by one instruction cycle.
// - Clock select sets bit period, acquisition count stays in bit periods.
// - A conversion continues while the device sits in idle.
// - Output-direction pins convert the level their own driver produces.
// - Conversion runs regardless of channel select or direction bits.
// - Port data reads return zero for analog-configured pins.
// - Digital-configured pins can also be converted normally.
// - Configuration bit picks port B analog or digital at reset.
// - Result registers hold new result on the cycle after completion.
// - Converter returns from convert to sample on next device clock.
// - Completion loads result, clears go bit and sets interrupt flag.
// - Reset restores registers, disables converter, aborts conversion.
// - Next acquisition waits at least two bit periods after conversion.
// - Four-bit channel select, codes 0-12 valid, 13-15 unimplemented.
module adcp_ctrl
    import adcp_pkg::*;
#(
    parameter int NUM_CHAN = 13
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic rc_tick_i,
    input wire logic sleep_i,
    input wire logic portb_analog_reset_select_i,
    input wire logic [NUM_CHAN-1:0] pin_level_i,
    input wire logic [NUM_CHAN-1:0] pin_dir_in_i,
    input wire logic cmp_i,
    output logic [11:0] dac_code_o,
    output logic [3:0] chan_sel_o,
    output logic sample_o,
    output logic irq_o
);
    // Refuse channel counts the select field and pin mask cannot serve
    if (NUM_CHAN < 1 || NUM_CHAN > 13) begin : g_chan_check
        $error("NUM_CHAN must be 1..13");
    end

    // Register state
    logic [7:0] ctrl0_r;
    logic [3:0] pin_function_field_r;
    logic [7:0] ctrl2_r;
    logic [11:0] result_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [7:0] port_a_direction_r;
    logic [7:0] port_b_direction_r;
    logic [7:0] port_e_direction_r;
    logic pcfg_loaded_r;
    adcp_state_t state_r;
    logic [5:0] div_cnt_r;
    logic tad_tick;
    logic [4:0] tcnt_r;
    logic [11:0] sar_r;
    logic [3:0] bit_r;
    logic sync1_r;
    logic sync2_r;
    logic done_p;
    logic abort_p;
    logic [6:0] div_len;
    logic [2:0] acq_tad;

    wire logic converter_on = ctrl0_r[ON_BIT];
    wire logic go_bit = ctrl0_r[GO_BIT];
    wire logic [3:0] input_channel_select = ctrl0_r[CHS_LSB +: 4];
    wire logic [2:0] conv_clock_select = ctrl2_r[CS_LSB +: 3];
    wire logic [2:0] acquisition_time_select = ctrl2_r[ACQ_LSB +: 3];

    // Device-clock divide for a bit period, per select code
    function automatic logic [6:0] divide_of(input logic [2:0] sel);
        unique case (sel[1:0])
            2'b00: divide_of = 7'd2;
            2'b01: divide_of = 7'd8;
            2'b10: divide_of = 7'd32;
            2'b11: divide_of = 7'd1;
        endcase
        if (sel[2]) begin
            divide_of = divide_of << 1;
        end
    endfunction : divide_of

    // Acquisition length in bit periods, per select code
    function automatic logic [4:0] acq_of(input logic [2:0] sel);
        unique case (sel)
            3'd0: acq_of = 5'd0;
            3'd1: acq_of = 5'd2;
            3'd2: acq_of = 5'd4;
            3'd3: acq_of = 5'd6;
            3'd4: acq_of = 5'd8;
            3'd5: acq_of = 5'd12;
            3'd6: acq_of = 5'd16;
            3'd7: acq_of = 5'd20;
        endcase
    endfunction : acq_of

    assign div_len = divide_of(conv_clock_select);
    assign acq_tad = acquisition_time_select;

    // RC tick crosses two flops; only the second is read
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else if (ce_i) begin
            sync1_r <= rc_tick_i;
            sync2_r <= sync1_r;
        end
    end

    // Bit period: device clock divider or RC clock edge
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            div_cnt_r <= 6'd0;
        end else if (ce_i) begin
            if (state_r == ST_IDLE || 7'(div_cnt_r) + 7'd1 >= div_len) begin
                div_cnt_r <= 6'd0;
            end else begin
                div_cnt_r <= div_cnt_r + 6'd1;
            end
        end
    end
    logic rc_prev_r;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rc_prev_r <= 1'b0;
        end else if (ce_i) begin
            rc_prev_r <= sync2_r;
        end
    end
    // RC mode keeps running in sleep; divider needs the device clock awake
    assign tad_tick = (conv_clock_select[1:0] == 2'b11) ? (sync2_r & ~rc_prev_r)
        : (~sleep_i && 7'(div_cnt_r) + 7'd1 >= div_len);

    // Conversion sequencer; idle mode does not stop it
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            tcnt_r <= 5'd0;
            sar_r <= 12'h000;
            bit_r <= 4'd0;
        end else if (ce_i) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (converter_on && go_bit) begin
                        tcnt_r <= 5'd0;
                        sar_r <= 12'h000;
                        if (acq_tad == 3'd0) begin
                            state_r <= ST_DELAY;
                        end else begin
                            state_r <= ST_ACQ;
                        end
                    end
                end
                ST_DELAY: begin
                    if (tcnt_r == 5'(TCY_CLKS - 1)) begin
                        state_r <= ST_CONV;
                        bit_r <= 4'(CONV_BITS - 1);
                        sar_r <= 12'h800;
                        tcnt_r <= 5'd0;
                    end else begin
                        tcnt_r <= tcnt_r + 5'd1;
                    end
                end
                ST_ACQ: begin
                    if (!converter_on) begin
                        state_r <= ST_IDLE;
                    end else if (tad_tick) begin
                        if (tcnt_r + 5'd1 >= acq_of(acq_tad)) begin
                            state_r <= ST_CONV;
                            bit_r <= 4'(CONV_BITS - 1);
                            sar_r <= 12'h800;
                            tcnt_r <= 5'd0;
                        end else begin
                            tcnt_r <= tcnt_r + 5'd1;
                        end
                    end
                end
                ST_CONV: begin
                    if (!converter_on) begin
                        state_r <= ST_IDLE;
                    end else if (tad_tick) begin
                        // Successive approximation, one bit per period
                        if (!cmp_i) begin
                            sar_r[bit_r] <= 1'b0;
                        end
                        if (bit_r == 4'd0) begin
                            state_r <= ST_GAP;
                            tcnt_r <= 5'd0;
                        end else begin
                            sar_r[bit_r - 4'd1] <= 1'b1;
                            bit_r <= bit_r - 4'd1;
                        end
                    end
                end
                ST_GAP: begin
                    if (tad_tick) begin
                        if (tcnt_r == 5'(GAP_TAD - 1)) begin
                            state_r <= ST_IDLE;
                        end else begin
                            tcnt_r <= tcnt_r + 5'd1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign done_p = ce_i && state_r == ST_CONV && converter_on && tad_tick && bit_r == 4'd0;
    assign abort_p = ce_i && !converter_on && (state_r == ST_ACQ || state_r == ST_CONV);

    // Sampling switch closed outside conversion; closes again right after it ends
    assign sample_o = (state_r != ST_CONV);
    assign dac_code_o = sar_r;
    // Mux follows select whatever the pin is configured as
    assign chan_sel_o = input_channel_select;

    // Control 0: go bit cleared by hardware on completion
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl0_r <= CTRL0_RST;
        end else if (ce_i) begin
            if (wr_i && addr_i == OFS_CTRL0) begin
                ctrl0_r <= {2'b00, wdata_i[5:0]};
            end
            if (done_p || abort_p) begin
                ctrl0_r[GO_BIT] <= 1'b0;
            end
        end
    end

    // Pin-function field reset value follows the configuration strap
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin_function_field_r <= PCFG_RST_ANALOG;
            pcfg_loaded_r <= 1'b0;
        end else if (ce_i) begin
            if (!pcfg_loaded_r) begin
                pcfg_loaded_r <= 1'b1;
                pin_function_field_r <= portb_analog_reset_select_i ? PCFG_RST_ANALOG
                    : PCFG_RST_DIGITAL;
            end else if (wr_i && addr_i == OFS_CTRL1) begin
                pin_function_field_r <= wdata_i[3:0];
            end
        end
    end

    // Control 2, directions and mask registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl2_r <= CTRL2_RST;
            irq_mask_r <= 2'b00;
            port_a_direction_r <= 8'hff;
            port_b_direction_r <= 8'hff;
            port_e_direction_r <= 8'hff;
        end else if (ce_i && wr_i) begin
            unique case (addr_i)
                OFS_CTRL2: ctrl2_r <= wdata_i;
                OFS_IRQ_MASK: irq_mask_r <= wdata_i[1:0];
                OFS_PORT_A: port_a_direction_r <= wdata_i;
                OFS_PORT_B: port_b_direction_r <= wdata_i;
                OFS_PORT_E: port_e_direction_r <= wdata_i;
                default: ;
            endcase
        end
    end

    // Result pair loaded at completion, readable next cycle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            result_r <= 12'h000;
        end else if (ce_i && done_p) begin
            result_r <= {sar_r[11:1], cmp_i};
        end
    end

    // Sticky events: write one to clear, set wins
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_stat_r <= 2'b00;
        end else if (ce_i) begin
            for (int i = 0; i < 2; i++) begin
                if (wr_i && addr_i == OFS_IRQ_STAT && wdata_i[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
            if (done_p) begin
                irq_stat_r[IRQ_DONE] <= 1'b1;
            end
            if (abort_p) begin
                irq_stat_r[IRQ_ABORT] <= 1'b1;
            end
        end
    end
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // Analog pins read low; channel n analog when n below field threshold
    function automatic logic [7:0] port_mask(input logic [3:0] pcfg, input int base);
        port_mask = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (base + i < NUM_CHAN && (base + i) < (15 - int'(pcfg))) begin
                port_mask[i] = 1'b1;
            end
        end
    endfunction : port_mask

    logic [15:0] pins_ext;
    assign pins_ext = 16'(pin_level_i);

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= 8'h00;
            if (rd_i) begin
                unique case (addr_i)
                    OFS_CTRL0: rdata_o <= ctrl0_r;
                    OFS_CTRL1: rdata_o <= {4'h0, pin_function_field_r};
                    OFS_CTRL2: rdata_o <= ctrl2_r;
                    OFS_RES_HI: rdata_o <= {4'h0, result_r[11:8]};
                    OFS_RES_LO: rdata_o <= result_r[7:0];
                    OFS_IRQ_STAT: rdata_o <= {6'h00, irq_stat_r};
                    OFS_IRQ_MASK: rdata_o <= {6'h00, irq_mask_r};
                    OFS_PORT_A: rdata_o <= pins_ext[7:0]
                        & ~port_mask(pin_function_field_r, 0);
                    OFS_PORT_B: rdata_o <= pins_ext[15:8]
                        & ~port_mask(pin_function_field_r, 8);
                    OFS_PORT_E: rdata_o <= port_e_direction_r;
                    OFS_STATUS: rdata_o <= {5'h00, 3'(state_r)};
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // Checks
    AST_DONE_CLEARS_GO: assert property (@(posedge clock_i) disable iff (rst_i)
        done_p |=> !ctrl0_r[GO_BIT] && irq_stat_r[IRQ_DONE]) else $error("done did not clear go");
    AST_RESULT_NEXT: assert property (@(posedge clock_i) disable iff (rst_i)
        done_p |=> result_r[11:1] == $past(sar_r[11:1])) else $error("result not loaded");
    AST_DELAY_TCY: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_r == ST_IDLE && ce_i && converter_on && go_bit && acq_tad == 3'd0)
        |=> state_r == ST_DELAY) else $error("no start delay");
    AST_SAMPLE_BACK: assert property (@(posedge clock_i) disable iff (rst_i)
        done_p |=> sample_o) else $error("sample not restored");
    AST_GAP_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_r == ST_CONV && done_p) |=> state_r == ST_GAP) else $error("gap skipped");
    AST_RESET_IDLE: assert property (@(posedge clock_i)
        rst_i |=> state_r == ST_IDLE && ctrl0_r == CTRL0_RST) else $error("reset not idle");
    AST_CHAN_FOLLOW: assert property (@(posedge clock_i) disable iff (rst_i)
        chan_sel_o == ctrl0_r[CHS_LSB +: 4]) else $error("channel mux wrong");
    AST_IRQ_LEVEL: assert property (@(posedge clock_i) disable iff (rst_i)
        irq_o == |(irq_stat_r & irq_mask_r)) else $error("irq level wrong");
endmodule : adcp_ctrl

//--- rtl/adcp_pkg.sv
// Package for the converter control block: register offsets, fields, resets, timing.
// Assumes a single 100 MHz system clock domain and an 8-bit register port.
package adcp_pkg;
    // Register offsets (byte index on the plain register port)
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h1;
    localparam logic [3:0] OFS_CTRL2 = 4'h2;
    localparam logic [3:0] OFS_RES_HI = 4'h3;
    localparam logic [3:0] OFS_RES_LO = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
    localparam logic [3:0] OFS_PORT_A = 4'h7;
    localparam logic [3:0] OFS_PORT_B = 4'h8;
    localparam logic [3:0] OFS_PORT_E = 4'h9;
    localparam logic [3:0] OFS_STATUS = 4'ha;
    // Control 0 fields
    localparam int ON_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int CHS_LSB = 2;
    // Control 2 fields
    localparam int CS_LSB = 0;
    localparam int ACQ_LSB = 3;
    // Reset values
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [3:0] PCFG_RST_ANALOG = 4'h0;
    localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;
    localparam logic [3:0] CHAN_LAST = 4'hc;
    // Timing: instruction cycle is four device clocks
    localparam int CLK_MHZ = 100;
    localparam int TCY_CLKS = 4;
    localparam int CONV_BITS = 12;
    localparam int CONV_TAD = 13;
    localparam int GAP_TAD = 2;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_ACQ,
        ST_CONV,
        ST_GAP
    } adcp_state_t;
endpackage : adcp_pkg

//--- verif/tb_adcp_ctrl.sv
// Self-checking bench for the converter control block: register port, conversions,
// clock choice, pin read-back, interrupt and reset abort.
// Assumes the design package and adcp_ctrl from rtl/; clock enable is held high.
module tb_adcp_ctrl
    import adcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rc_tick_i = 1'b0;
    logic sleep_i = 1'b0;
    logic strap_i = 1'b1;
    logic [12:0] pin_level_i = 13'h1fff;
    logic [12:0] pin_dir_in_i = 13'h1fff;
    wire logic cmp_i;
    wire logic [7:0] rdata_o;
    wire logic [11:0] dac_code_o;
    wire logic [3:0] chan_sel_o;
    wire logic sample_o;
    wire logic irq_o;
    logic [11:0] target = 12'h000;
    logic [4:0] rc_cnt = 5'h00;
    int n_mismatch = 0;
    int n_compared = 0;

    adcp_ctrl #(.NUM_CHAN(13)) dut_u (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rc_tick_i(rc_tick_i), .sleep_i(sleep_i),
        .portb_analog_reset_select_i(strap_i), .pin_level_i(pin_level_i),
        .pin_dir_in_i(pin_dir_in_i), .cmp_i(cmp_i), .dac_code_o(dac_code_o),
        .chan_sel_o(chan_sel_o), .sample_o(sample_o), .irq_o(irq_o)
    );

    // 100 MHz system clock
    initial begin
        forever #5 clock_i = ~clock_i;
    end

    // Ideal comparator on the trial code, settles within the cycle
    assign cmp_i = (dac_code_o <= target);
    // Free-running RC tick, 20 clocks a period
    always @(posedge clock_i) begin
        rc_cnt <= (rc_cnt == 5'd19) ? 5'd0 : rc_cnt + 5'd1;
        rc_tick_i <= (rc_cnt < 5'd10);
    end

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
            n_mismatch++;
        end
    endtask : chk_rng

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    // Starts a conversion, times the lead-in and the sample-low span, checks the result
    task automatic conv(input logic [2:0] cs, input logic [2:0] acq, input logic [3:0] ch,
                        input logic [11:0] tgt, output int lead, output int dur);
        logic [7:0] v;
        target = tgt;
        wr(OFS_CTRL2, {2'b00, acq, cs});
        wr(OFS_CTRL0, {2'b00, ch, 2'b11});
        lead = 0;
        dur = 0;
        #1;
        while (sample_o === 1'b1 && lead < 400) begin
            @(posedge clock_i);
            #1;
            lead++;
        end
        while (sample_o !== 1'b1 && dur < 2000) begin
            @(posedge clock_i);
            #1;
            dur++;
        end
        chk_rng("conv_time", 1, 1999, dur);
        chk("chan", {8'h00, ch}, {8'h00, chan_sel_o});
        chk("dac", tgt, dac_code_o);
        rd(OFS_CTRL0, v);
        chk("go", 12'h000, {11'h0, v[GO_BIT]});
        rd(OFS_RES_HI, v);
        chk("res_hi", {8'h00, tgt[11:8]}, {4'h0, v});
        rd(OFS_RES_LO, v);
        chk("res_lo", {4'h0, tgt[7:0]}, {4'h0, v});
    endtask : conv

    task automatic t_reset;
        logic [7:0] v;
        rd(OFS_CTRL0, v);
        chk("ctrl0", {4'h0, CTRL0_RST}, {4'h0, v});
        rd(OFS_CTRL1, v);
        chk("ctrl1", {8'h00, PCFG_RST_ANALOG}, {4'h0, v});
        rd(OFS_CTRL2, v);
        chk("ctrl2", {4'h0, CTRL2_RST}, {4'h0, v});
        rd(4'hf, v);
        chk("unmapped", 12'h000, {4'h0, v});
        chk("sample", 12'h001, {11'h0, sample_o});
    endtask : t_reset

    // Conversion, clock divider scaling, then interrupt masking and clearing
    task automatic t_conv_irq;
        int l1, d1, l5, d5;
        logic [7:0] v;
        wr(OFS_IRQ_MASK, 8'h01);
        conv(3'd1, 3'd0, 4'd0, 12'ha5c, l1, d1);
        chk_rng("lead", TCY_CLKS, TCY_CLKS + 2, l1);
        chk("irq", 12'h001, {11'h0, irq_o});
        conv(3'd5, 3'd0, 4'd12, 12'h0f3, l5, d5);
        chk_rng("dur_x2", 2 * d1 - 4, 2 * d1 + 4, d5);
        wr(OFS_IRQ_MASK, 8'h00);
        @(posedge clock_i);
        #1;
        chk("irq_masked", 12'h000, {11'h0, irq_o});
        rd(OFS_IRQ_STAT, v);
        chk("stat", 12'h001, {11'h0, v[IRQ_DONE]});
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_IRQ_STAT, 8'h01);
        @(posedge clock_i);
        #1;
        chk("irq_clr", 12'h000, {11'h0, irq_o});
    endtask : t_conv_irq

    // Digital pins, output direction and an unimplemented channel still convert
    task automatic t_pins;
        int l, d;
        logic [7:0] v;
        wr(OFS_CTRL1, 8'h0f);
        pin_dir_in_i <= 13'h0000;
        rd(OFS_PORT_A, v);
        n_compared++;
        if (v === 8'h00) begin
            $display("Error port_a_digital expected nonzero seen %h", v);
            n_mismatch++;
        end
        conv(3'd1, 3'd2, 4'd13, 12'h3c1, l, d);
        wr(OFS_CTRL1, 8'h00);
        rd(OFS_PORT_A, v);
        chk("port_a", 12'h000, {4'h0, v});
        rd(OFS_PORT_B, v);
        chk("port_b", 12'h000, {4'h0, v});
        pin_dir_in_i <= 13'h1fff;
    endtask : t_pins

    // RC clock keeps converting while the system divider is stopped
    task automatic t_sleep;
        int l, d;
        sleep_i <= 1'b1;
        conv(3'd3, 3'd0, 4'd3, 12'h7e2, l, d);
        sleep_i <= 1'b0;
    endtask : t_sleep

    // Turning off mid-run and a reset mid-run both abort
    task automatic t_abort;
        logic [7:0] v;
        target = 12'h555;
        wr(OFS_CTRL2, 8'h09);
        wr(OFS_CTRL0, 8'h03);
        repeat (30) @(posedge clock_i);
        wr(OFS_CTRL0, 8'h00);
        repeat (2) @(posedge clock_i);
        #1;
        chk("sample_off", 12'h001, {11'h0, sample_o});
        rd(OFS_IRQ_STAT, v);
        chk("abort", 12'h001, {11'h0, v[IRQ_ABORT]});
        wr(OFS_CTRL0, 8'h03);
        repeat (30) @(posedge clock_i);
        rst_i <= 1'b1;
        strap_i <= 1'b0;
        @(posedge clock_i);
        rst_i <= 1'b0;
        #1;
        chk("sample_rst", 12'h001, {11'h0, sample_o});
        chk("irq_rst", 12'h000, {11'h0, irq_o});
        rd(OFS_CTRL0, v);
        chk("ctrl0_rst", {4'h0, CTRL0_RST}, {4'h0, v});
        rd(OFS_CTRL1, v);
        chk("ctrl1_dig", {8'h00, PCFG_RST_DIGITAL}, {4'h0, v});
    endtask : t_abort

    task automatic summarize;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_conv_irq();
        t_pins();
        t_sleep();
        t_abort();
        summarize();
    end

    // Watchdog well beyond the expected run of about a thousand cycles
    initial begin
        repeat (50000) @(posedge clock_i);
        n_mismatch++;
        summarize();
    end
endmodule : tb_adcp_ctrl
